// *** core/tmr_cfg.svh ***
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define TMR_OFS_PRESCALER   8'hd2
`define TMR_OFS_COUNT       8'hd3
`define TMR_OFS_STATUS      8'hd4

// ----------------------------------------------------------------------------
// Status/control field positions
// ----------------------------------------------------------------------------
`define TMR_BIT_ZERO        7
`define TMR_BIT_IRQ_EN      6
`define TMR_BIT_DIR         5
`define TMR_BIT_DOUT        4
`define TMR_BIT_INIT        3
`define TMR_SEL_MSB         2
`define TMR_SEL_LSB         0
`define TMR_PSC_MSB         6

// ----------------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------------
`define TMR_RST_PRESCALER   7'h7f
`define TMR_RST_COUNT       8'hff
`define TMR_RST_STATUS      8'h00
`define TMR_COUNT_ZERO      8'h00
`define TMR_READ_IDLE       8'h00
`define TMR_CORE_DIV        12

`endif

// *** core/tmr_pkg.sv ***
package tmr_pkg;

    // Operating mode, decoded from direction and data-out bits
    typedef enum logic [1:0] {
        TMR_MODE_EVENT  = 2'b00,
        TMR_MODE_GATED  = 2'b01,
        TMR_MODE_OUTPUT = 2'b11
    } tmr_mode_e;

    typedef logic [7:0] tmr_byte_t;
    typedef logic [6:0] tmr_psc_t;
    typedef logic [2:0] tmr_sel_t;

endpackage

// *** core/tmr_sync.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------------
module tmr_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      level_out
);

    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;
    logic level_ff;

    // Stage 1 feeds stage 2 only; metastability must not reach any gate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // A change is accepted once stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_ff <= 1'b0;
        end else if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
        end
    end

    assign level_out = level_ff;

endmodule

// *** core/tmr_core.sv ***
// Summary of operation
// - Counter decrements on each selected tap rising edge; reaching zero sets zero flag.
// - Interrupt request is high exactly when irq enable and zero flag are both one.
// - Prescaler source is core clock divided by twelve or the timer pin.
// - Tap 1 is the prescaler input itself; tap 2^n is prescaler bit n-1.
// - Three-bit select gives division factor two to the power of its value.
// - Init bit low holds prescaler at all ones and stops prescaler and counter.
// - With init bit high, software may write any prescaler value 0 to 7Fh.
// - Gated mode counts divided core clock only while the timer pin is high.
// - Event mode counts rising edges of the timer pin.
// - Output mode counts divided core clock and drives the timer pin.
// - Pin latch follows data-out while zero flag high, holds when it falls.
// - Zero flag also set by writing 00h to counter or one to bit 7.
// - Reset loads counter FFh, prescaler 7Fh, clears status/control register.
// - Counter write beats a coincident decrement to zero; no flag from that decrement.
// - Counter and prescaler read live at any time without disturbing counting.
// - Prescaler register bit 7 reads zero; low seven bits hold the value.
// - Direction bit makes the timer pin input when zero, output when one.
// - Interrupt request is a plain level usable to leave the wait state.
//
// The strobed register port is this design's own decision.

`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_core #(
    parameter int PRE_DIV = `TMR_CORE_DIV
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_pin_in,
    output logic            timer_pin_out,
    output logic            timer_pin_oe,
    output logic            timer_irq
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    function automatic tmr_pkg::tmr_mode_e mode_decode(input logic dir, input logic dout);
        tmr_pkg::tmr_mode_e m;
        m = tmr_pkg::TMR_MODE_EVENT;
        if (dir) begin
            m = tmr_pkg::TMR_MODE_OUTPUT;
        end else if (dout) begin
            m = tmr_pkg::TMR_MODE_GATED;
        end
        return m;
    endfunction

    // True when the selected tap sees a rising edge as the prescaler steps
    function automatic logic tap_rise(input tmr_pkg::tmr_sel_t sel,
                                      input tmr_pkg::tmr_psc_t old_val,
                                      input tmr_pkg::tmr_psc_t new_val);
        logic hit;
        hit = 1'b0;
        if (sel == 3'h0) begin
            hit = 1'b1;
        end else begin
            hit = ~old_val[sel - 3'h1] & new_val[sel - 3'h1];
        end
        return hit;
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------

    localparam logic [3:0] DIV_LAST = 4'(PRE_DIV - 1);

    logic [3:0]              div_cnt_ff;
    logic                    div_tick_ff;
    logic                    pin_level;
    logic                    pin_level_d_ff;
    logic                    pin_rise;

    tmr_pkg::tmr_psc_t       psc_ff;
    tmr_pkg::tmr_psc_t       nxt_psc;
    tmr_pkg::tmr_psc_t       psc_dec;
    tmr_pkg::tmr_byte_t      cnt_ff;
    tmr_pkg::tmr_byte_t      nxt_cnt;
    tmr_pkg::tmr_byte_t      cnt_dec;

    logic                    zero_ff;
    logic                    nxt_zero;
    logic                    zero_set;
    logic                    irq_en_ff;
    logic                    nxt_irq_en;
    logic                    dir_ff;
    logic                    nxt_dir;
    logic                    dout_ff;
    logic                    nxt_dout;
    logic                    init_ff;
    tmr_pkg::tmr_sel_t       sel_ff;

    tmr_pkg::tmr_mode_e      mode;
    logic                    src_ev;
    logic                    cnt_ev;

    logic                    wr_psc;
    logic                    wr_cnt;
    logic                    wr_stat;

    tmr_pkg::tmr_byte_t      rdata_ff;
    tmr_pkg::tmr_byte_t      nxt_rdata;
    logic                    irq_ff;
    logic                    pin_out_ff;
    logic                    pin_oe_ff;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------

    assign wr_psc  = reg_wr && (reg_addr == `TMR_OFS_PRESCALER);
    assign wr_cnt  = reg_wr && (reg_addr == `TMR_OFS_COUNT);
    assign wr_stat = reg_wr && (reg_addr == `TMR_OFS_STATUS);

    // ------------------------------------------------------------------------
    // Core clock divider and pin conditioning
    // ------------------------------------------------------------------------

    // Free-running so a gated measurement keeps its phase between pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt_ff  <= 4'h0;
            div_tick_ff <= 1'b0;
        end else if (div_cnt_ff == DIV_LAST) begin
            div_cnt_ff  <= 4'h0;
            div_tick_ff <= 1'b1;
        end else begin
            div_cnt_ff  <= div_cnt_ff + 4'h1;
            div_tick_ff <= 1'b0;
        end
    end

    tmr_sync u_pin_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .async_in  (timer_pin_in),
        .level_out (pin_level)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_level_d_ff <= 1'b0;
        end else begin
            pin_level_d_ff <= pin_level;
        end
    end

    assign pin_rise = pin_level & ~pin_level_d_ff;

    // ------------------------------------------------------------------------
    // Prescaler source selection
    // ------------------------------------------------------------------------

    assign mode = mode_decode(dir_ff, dout_ff);

    always_comb begin
        src_ev = 1'b0;
        case (mode)
            tmr_pkg::TMR_MODE_EVENT: begin
                src_ev = pin_rise;
            end
            tmr_pkg::TMR_MODE_GATED: begin
                src_ev = div_tick_ff & pin_level;
            end
            tmr_pkg::TMR_MODE_OUTPUT: begin
                src_ev = div_tick_ff;
            end
            default: begin
                src_ev = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------------

    assign psc_dec = psc_ff - 7'h01;

    always_comb begin
        nxt_psc = psc_ff;
        if (!init_ff) begin
            nxt_psc = `TMR_RST_PRESCALER;
        end else if (wr_psc) begin
            nxt_psc = reg_wdata[`TMR_PSC_MSB:0];
        end else if (src_ev) begin
            nxt_psc = psc_dec;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            psc_ff <= `TMR_RST_PRESCALER;
        end else begin
            psc_ff <= nxt_psc;
        end
    end

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------

    // A prescaler write in the same cycle replaces the step, so no tap edge
    assign cnt_ev  = init_ff & src_ev & ~wr_psc & tap_rise(sel_ff, psc_ff, psc_dec);
    assign cnt_dec = cnt_ff - 8'h01;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (wr_cnt) begin
            nxt_cnt = reg_wdata;
        end else if (cnt_ev) begin
            nxt_cnt = cnt_dec;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= `TMR_RST_COUNT;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------------
    // Zero flag
    // ------------------------------------------------------------------------

    // Any set source beats a software clear written in the same cycle
    always_comb begin
        zero_set = 1'b0;
        if (cnt_ev && !wr_cnt && (cnt_dec == `TMR_COUNT_ZERO)) begin
            zero_set = 1'b1;
        end
        if (wr_cnt && (reg_wdata == `TMR_COUNT_ZERO)) begin
            zero_set = 1'b1;
        end
        if (wr_stat && reg_wdata[`TMR_BIT_ZERO]) begin
            zero_set = 1'b1;
        end
    end

    always_comb begin
        nxt_zero = zero_ff;
        if (zero_set) begin
            nxt_zero = 1'b1;
        end else if (wr_stat) begin
            nxt_zero = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            zero_ff <= 1'(`TMR_RST_STATUS >> `TMR_BIT_ZERO);
        end else begin
            zero_ff <= nxt_zero;
        end
    end

    // ------------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------------

    assign nxt_irq_en = wr_stat ? reg_wdata[`TMR_BIT_IRQ_EN] : irq_en_ff;
    assign nxt_dir    = wr_stat ? reg_wdata[`TMR_BIT_DIR]    : dir_ff;
    assign nxt_dout   = wr_stat ? reg_wdata[`TMR_BIT_DOUT]   : dout_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_en_ff <= 1'b0;
            dir_ff    <= 1'b0;
            dout_ff   <= 1'b0;
            init_ff   <= 1'b0;
            sel_ff    <= 3'h0;
        end else begin
            irq_en_ff <= nxt_irq_en;
            dir_ff    <= nxt_dir;
            dout_ff   <= nxt_dout;
            if (wr_stat) begin
                init_ff <= reg_wdata[`TMR_BIT_INIT];
                sel_ff  <= reg_wdata[`TMR_SEL_MSB:`TMR_SEL_LSB];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------------

    // Level output with no clock dependence downstream, so a sleeping core
    // can use it as its wake source
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_zero & nxt_irq_en;
        end
    end

    // ------------------------------------------------------------------------
    // Timer pin driver
    // ------------------------------------------------------------------------

    // Latch is transparent while the flag is high; in input mode the value
    // is kept but not driven
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out_ff <= 1'b0;
        end else if (nxt_zero) begin
            pin_out_ff <= nxt_dout;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_oe_ff <= 1'b0;
        end else begin
            pin_oe_ff <= nxt_dir;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------

    always_comb begin
        nxt_rdata = `TMR_READ_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                `TMR_OFS_PRESCALER: begin
                    nxt_rdata = {1'b0, psc_ff};
                end
                `TMR_OFS_COUNT: begin
                    nxt_rdata = cnt_ff;
                end
                `TMR_OFS_STATUS: begin
                    nxt_rdata = {zero_ff, irq_en_ff, dir_ff, dout_ff, init_ff, sel_ff};
                end
                default: begin
                    nxt_rdata = `TMR_READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= `TMR_READ_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    assign reg_rdata     = rdata_ff;
    assign timer_irq     = irq_ff;
    assign timer_pin_out = pin_out_ff;
    assign timer_pin_oe  = pin_oe_ff;

endmodule

// *** test/tmr_core_monitor.sv ***
`timescale 1ns/1ps

// --------
// Port checker
// --------
module tmr_core_monitor (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       timer_pin_in,
    input wire logic       timer_pin_out,
    input wire logic       timer_pin_oe,
    input wire logic       timer_irq
);
    logic en_ff;
    logic init_ff;

    // Shadows of enable and run bits; the flag itself is hidden behind irq
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_ff   <= 1'b0;
            init_ff <= 1'b0;
        end else if (reg_wr && reg_addr == 8'hd4) begin
            en_ff   <= reg_wdata[6];
            init_ff <= reg_wdata[3];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    psc_msb_a: assert property (reg_rd && reg_addr == 8'hd2 |=> reg_rdata[7] == 1'b0)
        else $error("prescaler msb not zero");
    zero_write_a: assert property (reg_wr && reg_addr == 8'hd3 && reg_wdata == 8'h00 && en_ff |=> timer_irq)
        else $error("counter clear did not raise request");
    flag_set_a: assert property (reg_wr && reg_addr == 8'hd4 && reg_wdata[7:6] == 2'b11 |=> timer_irq)
        else $error("flag write did not raise request");
    irq_mask_a: assert property (!en_ff |-> !timer_irq)
        else $error("request while disabled");
    flag_clear_a: assert property (reg_wr && reg_addr == 8'hd4 && !reg_wdata[7] && !init_ff |=> !timer_irq)
        else $error("request after flag clear");
    stop_hold_a: assert property (!reg_wr && !init_ff && !$past(init_ff) |=> $stable(timer_irq))
        else $error("request moved while stopped");
    oe_dir_a: assert property (reg_wr && reg_addr == 8'hd4 |=> timer_pin_oe == $past(reg_wdata[5]))
        else $error("pin enable differs from direction");
    pin_follow_a: assert property (reg_wr && reg_addr == 8'hd4 && reg_wdata[7]
        |=> timer_pin_out == $past(reg_wdata[4]))
        else $error("pin did not follow data out");
    pin_hold_a: assert property (en_ff && !timer_irq ##1 en_ff && !timer_irq |-> $stable(timer_pin_out))
        else $error("pin moved while flag low");
endmodule

bind tmr_core tmr_core_monitor i_mon (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
    .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq)
);

// *** test/tmr_pin_model.sv ***
`timescale 1ns/1ps

// --------
// Source or load on the timer pin
// --------
module tmr_pin_model (
    input  wire logic clk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_in
);
    logic src_ff = 1'b0;

    // The block wins the wire in output mode, the source otherwise
    assign pin_in = pin_oe ? pin_out : src_ff;

    // Rising edges for counting; width in clocks, slow widths too
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            src_ff <= 1'b1;
            repeat (w) @(posedge clk);
            src_ff <= 1'b0;
            repeat (w - 1) @(posedge clk);
        end
    endtask

    task automatic hold_high(input int w);
        @(posedge clk);
        src_ff <= 1'b1;
        repeat (w) @(posedge clk);
        src_ff <= 1'b0;
    endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    logic       clk;
    logic       sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       timer_pin_in;
    logic       timer_pin_out;
    logic       timer_pin_oe;
    logic       timer_irq;
    logic [7:0] rv;
    logic [2:0] s;
    int         mismatches;
    int         checked;
    int         cycles = 0;
    int         took;

    tmr_core #(.PRE_DIV(12)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
        .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq)
    );

    tmr_pin_model i_pin (.clk(clk), .pin_out(timer_pin_out), .pin_oe(timer_pin_oe), .pin_in(timer_pin_in));

    always #10 clk = ~clk;

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Longest period is 3072 clocks; the whole run stays well below this 12000-cycle limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(what, exp, rv);
    endtask

    // Called at the edge that took a write; lets that edge settle first
    task automatic flag(input logic exp);
        #1;
        chk("irq", {7'h00, exp}, {7'h00, timer_irq});
    endtask

    task automatic wait_irq(input int limit);
        took = 0;
        do begin
            @(posedge clk);
            #1;
            took++;
        end while (timer_irq !== 1'b1 && took < limit);
    endtask

    initial begin
        clk       = 1'b0;
        sys_rst   = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;

        // --------
        // Reset state and software flag control
        // --------
        rdc(8'hd2, 8'h7f, "psc reset");
        rdc(8'hd3, 8'hff, "count reset");
        rdc(8'hd4, 8'h00, "status reset");
        rdc(8'hd5, 8'h00, "unmapped");
        chk("pin oe", 8'h00, {7'h00, timer_pin_oe});
        wr(8'hd2, 8'h55);
        rdc(8'hd2, 8'h7f, "psc held");
        wr(8'hd4, 8'h40);
        wr(8'hd3, 8'h00);
        flag(1'b1);
        rdc(8'hd4, 8'hc0, "status");
        wr(8'hd4, 8'h40);
        flag(1'b0);
        wr(8'hd4, 8'hd0);
        flag(1'b1);
        chk("pin out", 8'h01, {7'h00, timer_pin_out});
        wr(8'hd4, 8'h80);
        flag(1'b0);
        rdc(8'hd4, 8'h80, "status");

        // --------
        // Every division factor in output mode, counting 2 down to zero
        // --------
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            wr(8'hd4, {5'b00100, s});
            wr(8'hd3, 8'h02);
            wr(8'hd4, {3'b011, s[0], 1'b1, s});
            wait_irq(3200);
            chk("period", 8'h01, {7'h00, took >= 12 * ((2 << i) - 1) - 2 && took <= 12 * (2 << i) + 4});
            chk("irq", 8'h01, {7'h00, timer_irq});
            chk("pin out", {7'h00, s[0]}, {7'h00, timer_pin_out});
            chk("pin oe", 8'h01, {7'h00, timer_pin_oe});
            if (i == 0) begin
                // Steps now fall every 12 clocks after the zero edge
                rdc(8'hd3, 8'h00, "at zero");
                repeat (10) @(posedge clk);
                rdc(8'hd3, 8'hff, "wrap");
                chk("flag kept", 8'h01, {7'h00, timer_irq});
                repeat (9) @(posedge clk);
                wr(8'hd3, 8'h01);
                wr(8'hd4, 8'h68);
                repeat (7) @(posedge clk);
                wr(8'hd3, 8'h05);
                flag(1'b0);
                rdc(8'hd3, 8'h05, "write wins");
            end
        end

        // --------
        // Event counting and prescaler writes
        // --------
        wr(8'hd4, 8'h00);
        wr(8'hd3, 8'h10);
        wr(8'hd4, 8'h08);
        wr(8'hd2, 8'hff);
        rdc(8'hd2, 8'h7f, "psc msb");
        wr(8'hd2, 8'h23);
        rdc(8'hd2, 8'h23, "psc write");
        i_pin.pulses(5, 4);
        repeat (10) @(posedge clk);
        rdc(8'hd3, 8'h0b, "events");
        rdc(8'hd2, 8'h1e, "psc live");

        // --------
        // Gated counting, then stop
        // --------
        wr(8'hd4, 8'h00);
        wr(8'hd3, 8'h10);
        wr(8'hd4, 8'h18);
        repeat (40) @(posedge clk);
        rdc(8'hd2, 8'h7f, "gate low");
        i_pin.hold_high(120);
        repeat (10) @(posedge clk);
        rdc(8'hd3, 8'h06, "gate high");
        if ((rv >= 8'h05 && rv <= 8'h07) !== 1'b1) begin
            mismatches++;
            $display("[ERR] gated count expected 05..07 seen %h", rv);
        end
        wr(8'hd4, 8'h10);
        rdc(8'hd2, 8'h7f, "psc stop");
        give_verdict();
    end
endmodule
